//--- design/dmc_top.sv
// display memory controller: apb registers, refresh, copy engine, fetch, blanking
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dmc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	input  wire logic        vborder_in,
	input  wire logic [3:0]  pix_rgbi,
	output logic [3:0]       rgbi,
	output logic             hblank,
	output logic             underline,
	output logic [7:0]       pattern_data,
	output logic             pattern_valid,
	output logic [7:0]       ram_addr,
	output logic             ram_ras_n,
	output logic             ram_cas_n,
	output logic             ram_we_n,
	output logic [7:0]       ram_dout,
	output logic             ram_doe,
	input  wire logic [7:0]  ram_din
);
	logic [7:0] charset_r, uline_r, src_hi_r, src_lo_r, blk_begin_r, blk_end_r;
	logic [7:0] refresh_r, wcount_r, dst_hi_r, dst_lo_r, ctrl_r, line_tot_r;
	logic [7:0] disp_hi_r, disp_lo_r;
	logic       copy_busy_r, copy_wr_phase_r;
	logic [7:0] copy_data_r;
	logic [2:0] sub_r;
	logic [7:0] hcnt_r;
	logic [4:0] scan_r;
	logic [15:0] row_base_r, ptr_addr_r, refr_addr_r, acc_addr_r, acc_addr_nxt;
	logic [3:0] refr_left_r;
	logic [7:0] ptr_r;
	logic [15:0] copy_src_r, copy_dst_r;
	logic [7:0] copy_left_r;
	dmc_pkg::dmc_acc_t  acc_st_r;
	dmc_pkg::dmc_kind_t kind_r, kind_nxt;
	dmc_mux_if mif ();

	function automatic logic in_window(input logic [7:0] pos, input logic [7:0] lo, input logic [7:0] hi);
		in_window = (lo <= hi) ? (pos >= lo && pos <= hi) : (pos >= lo || pos <= hi);
	endfunction

	function automatic logic [15:0] pattern_addr(input logic [7:0] cs, input logic [4:0] height,
			input logic [7:0] ptr, input logic [4:0] scan);
		if (height > dmc_pkg::SHORT_HEIGHT_MAX) begin
			// 8192-byte sets: only the top two base bits remain
			pattern_addr = {cs[dmc_pkg::CS_MSB -: 2], 1'b0, ptr, scan[4:0]}; // see R6
		end else begin
			pattern_addr = {cs[dmc_pkg::CS_MSB:dmc_pkg::CS_LSB], 1'b0, ptr, scan[3:0]}; // see R5
		end
	endfunction

	// apb slave, zero wait states
	logic wr_en, rd_setup, addr_ok;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		unique case (paddr)
			dmc_pkg::OFF_CHARSET, dmc_pkg::OFF_ULINE, dmc_pkg::OFF_SRC_HI, dmc_pkg::OFF_SRC_LO,
			dmc_pkg::OFF_BLK_BEGIN, dmc_pkg::OFF_BLK_END, dmc_pkg::OFF_REFRESH, dmc_pkg::OFF_WCOUNT,
			dmc_pkg::OFF_DST_HI, dmc_pkg::OFF_DST_LO, dmc_pkg::OFF_CTRL, dmc_pkg::OFF_STATUS,
			dmc_pkg::OFF_LINE_TOT, dmc_pkg::OFF_DISP_HI, dmc_pkg::OFF_DISP_LO: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charset_r <= dmc_pkg::RST_ZERO;
			uline_r <= dmc_pkg::RST_ZERO;
			src_hi_r <= dmc_pkg::RST_ZERO;
			src_lo_r <= dmc_pkg::RST_ZERO;
			blk_begin_r <= dmc_pkg::RST_BLK_BEGIN;
			blk_end_r <= dmc_pkg::RST_BLK_END;
			refresh_r <= dmc_pkg::RST_REFRESH;
			wcount_r <= dmc_pkg::RST_ZERO;
			dst_hi_r <= dmc_pkg::RST_ZERO;
			dst_lo_r <= dmc_pkg::RST_ZERO;
			ctrl_r <= {3'h0, dmc_pkg::RST_HEIGHT};
			line_tot_r <= dmc_pkg::RST_LINE_TOT;
			disp_hi_r <= dmc_pkg::RST_ZERO;
			disp_lo_r <= dmc_pkg::RST_ZERO;
		end else if (wr_en) begin
			unique case (paddr)
				dmc_pkg::OFF_CHARSET: charset_r <= pwdata[7:0];
				dmc_pkg::OFF_ULINE: uline_r <= pwdata[7:0];
				dmc_pkg::OFF_SRC_HI: src_hi_r <= pwdata[7:0];
				dmc_pkg::OFF_SRC_LO: src_lo_r <= pwdata[7:0];
				dmc_pkg::OFF_BLK_BEGIN: blk_begin_r <= pwdata[7:0];
				dmc_pkg::OFF_BLK_END: blk_end_r <= pwdata[7:0];
				dmc_pkg::OFF_REFRESH: refresh_r <= pwdata[7:0];
				dmc_pkg::OFF_WCOUNT: wcount_r <= pwdata[7:0];
				dmc_pkg::OFF_DST_HI: dst_hi_r <= pwdata[7:0];
				dmc_pkg::OFF_DST_LO: dst_lo_r <= pwdata[7:0];
				dmc_pkg::OFF_CTRL: ctrl_r <= pwdata[7:0];
				dmc_pkg::OFF_LINE_TOT: line_tot_r <= pwdata[7:0];
				dmc_pkg::OFF_DISP_HI: disp_hi_r <= pwdata[7:0];
				dmc_pkg::OFF_DISP_LO: disp_lo_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= dmc_pkg::APB_OK;
		end else if (rd_setup) begin
			unique case (paddr)
				dmc_pkg::OFF_CHARSET: prdata <= {24'h0, charset_r};
				dmc_pkg::OFF_ULINE: prdata <= {24'h0, uline_r};
				dmc_pkg::OFF_SRC_HI: prdata <= {24'h0, src_hi_r};
				dmc_pkg::OFF_SRC_LO: prdata <= {24'h0, src_lo_r};
				dmc_pkg::OFF_BLK_BEGIN: prdata <= {24'h0, blk_begin_r};
				dmc_pkg::OFF_BLK_END: prdata <= {24'h0, blk_end_r};
				dmc_pkg::OFF_REFRESH: prdata <= {24'h0, refresh_r};
				dmc_pkg::OFF_WCOUNT: prdata <= {24'h0, wcount_r};
				dmc_pkg::OFF_DST_HI: prdata <= {24'h0, dst_hi_r};
				dmc_pkg::OFF_DST_LO: prdata <= {24'h0, dst_lo_r};
				dmc_pkg::OFF_CTRL: prdata <= {24'h0, ctrl_r};
				dmc_pkg::OFF_STATUS: prdata <= {24'h0, ~copy_busy_r, copy_busy_r, 6'h0};
				dmc_pkg::OFF_LINE_TOT: prdata <= {24'h0, line_tot_r};
				dmc_pkg::OFF_DISP_HI: prdata <= {24'h0, disp_hi_r};
				dmc_pkg::OFF_DISP_LO: prdata <= {24'h0, disp_lo_r};
				default: prdata <= dmc_pkg::APB_OK;
			endcase
		end
	end

	// character slot and horizontal position
	logic slot_end, line_end, in_blank, disp_act, acc_start, refr_due;
	logic [4:0] height;
	assign height = ctrl_r[dmc_pkg::HEIGHT_MSB:0];
	assign slot_end = (sub_r == dmc_pkg::SLOT_LAST);
	assign line_end = slot_end && (hcnt_r == line_tot_r);
	assign in_blank = in_window(hcnt_r, blk_begin_r, blk_end_r); // see R12 // see R13
	assign disp_act = ~in_blank & ~vsync_in & ~vborder_in;
	assign acc_start = (sub_r == dmc_pkg::SLOT_ACC0) || (sub_r == dmc_pkg::SLOT_ACC1);
	assign refr_due = in_blank && (refr_left_r != 4'h0); // see R17

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_r <= 3'h0;
			hcnt_r <= 8'h00;
		end else begin
			sub_r <= sub_r + 3'h1;
			if (slot_end) begin
				hcnt_r <= line_end ? 8'h00 : hcnt_r + 8'h01;
			end
		end
	end

	// scan line within the character row and row-major pointer walk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_r <= 5'h00;
			row_base_r <= 16'h0000;
		end else if (vsync_in) begin
			scan_r <= 5'h00;
			row_base_r <= {disp_hi_r, disp_lo_r}; // see R7
		end else if (line_end) begin
			if (scan_r >= height) begin
				scan_r <= 5'h00;
				row_base_r <= row_base_r + {8'h00, blk_begin_r}; // see R7
			end else begin
				scan_r <= scan_r + 5'h01;
			end
		end
	end

	// refresh budget reloads as every line's blanking opens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refr_left_r <= 4'h0;
			refr_addr_r <= 16'h0000;
		end else if (slot_end && (hcnt_r + 8'h01 == blk_begin_r)) begin
			refr_left_r <= refresh_r[dmc_pkg::REFR_MSB:0]; // see R14
		end else if (acc_start && refr_due) begin
			refr_left_r <= refr_left_r - 4'h1;
			refr_addr_r <= refr_addr_r + 16'h0001; // see R15
		end
	end

	// slot arbitration: refresh, then display fetch, then copy
	always_comb begin
		kind_nxt = dmc_pkg::DMC_K_NONE;
		acc_addr_nxt = acc_addr_r;
		if (refr_due) begin
			kind_nxt = dmc_pkg::DMC_K_REFR;
			acc_addr_nxt = refr_addr_r; // see R15
		end else if (disp_act) begin
			if (sub_r == dmc_pkg::SLOT_ACC0) begin
				kind_nxt = dmc_pkg::DMC_K_PTR;
				acc_addr_nxt = ptr_addr_r; // see R7
			end else begin
				kind_nxt = dmc_pkg::DMC_K_PAT;
				acc_addr_nxt = pattern_addr(charset_r, height, ptr_r, scan_r); // see R16
			end
		end else if (copy_busy_r) begin
			kind_nxt = copy_wr_phase_r ? dmc_pkg::DMC_K_CWR : dmc_pkg::DMC_K_CRD;
			acc_addr_nxt = copy_wr_phase_r ? copy_dst_r : copy_src_r; // see R10
		end
	end

	// three-cycle dram access: row strobe, column strobe, latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_st_r <= dmc_pkg::DMC_IDLE;
			kind_r <= dmc_pkg::DMC_K_NONE;
			acc_addr_r <= 16'h0000;
		end else begin
			unique case (acc_st_r)
				dmc_pkg::DMC_IDLE: if (acc_start && kind_nxt != dmc_pkg::DMC_K_NONE) begin
					acc_st_r <= dmc_pkg::DMC_ROW;
					kind_r <= kind_nxt;
					acc_addr_r <= acc_addr_nxt; // see R1
				end
				dmc_pkg::DMC_ROW: acc_st_r <= dmc_pkg::DMC_COL;
				dmc_pkg::DMC_COL: acc_st_r <= dmc_pkg::DMC_END;
				dmc_pkg::DMC_END: acc_st_r <= dmc_pkg::DMC_IDLE;
			endcase
		end
	end

	logic acc_done;
	assign acc_done = (acc_st_r == dmc_pkg::DMC_END);

	// display fetch results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= 8'h00;
			ptr_addr_r <= 16'h0000;
			pattern_data <= 8'h00;
			pattern_valid <= 1'b0;
		end else begin
			pattern_valid <= acc_done && kind_r == dmc_pkg::DMC_K_PAT;
			if (line_end) begin
				ptr_addr_r <= vsync_in ? {disp_hi_r, disp_lo_r} : row_base_r;
			end else if (acc_done && kind_r == dmc_pkg::DMC_K_PTR) begin
				ptr_r <= ram_din; // see R7
				ptr_addr_r <= ptr_addr_r + 16'h0001;
			end
			if (acc_done && kind_r == dmc_pkg::DMC_K_PAT) begin
				pattern_data <= ram_din;
			end
		end
	end

	// block copy engine; starts when the count is written in copy mode
	logic wcount_wr_start;
	assign wcount_wr_start = wr_en && (paddr == dmc_pkg::OFF_WCOUNT) && ctrl_r[dmc_pkg::COPY_MODE_BIT];

	// working counters kept apart so the host registers keep their programmed values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			copy_busy_r <= 1'b0;
			copy_wr_phase_r <= 1'b0;
			copy_data_r <= 8'h00;
			copy_src_r <= 16'h0000;
			copy_dst_r <= 16'h0000;
			copy_left_r <= 8'h00;
		end else if (wcount_wr_start) begin
			copy_busy_r <= (pwdata[7:0] != 8'h00);
			copy_wr_phase_r <= 1'b0;
			copy_src_r <= {src_hi_r, src_lo_r};
			copy_dst_r <= {dst_hi_r, dst_lo_r};
			copy_left_r <= pwdata[7:0];
		end else if (acc_done && kind_r == dmc_pkg::DMC_K_CRD) begin
			copy_data_r <= ram_din; // see R10
			copy_wr_phase_r <= 1'b1;
		end else if (acc_done && kind_r == dmc_pkg::DMC_K_CWR) begin
			copy_wr_phase_r <= 1'b0;
			copy_src_r <= copy_src_r + 16'h0001; // see R10
			copy_dst_r <= copy_dst_r + 16'h0001; // see R10
			copy_left_r <= copy_left_r - 8'h01;
			if (copy_left_r == 8'h01) begin
				copy_busy_r <= 1'b0;
			end
		end
	end

	// ram pins: ras spans the access, refresh is ras-only
	logic col_ph;
	assign col_ph = (acc_st_r == dmc_pkg::DMC_COL) || (acc_st_r == dmc_pkg::DMC_END);
	assign mif.addr = acc_addr_r;
	assign mif.ram_type = charset_r[dmc_pkg::RAM_TYPE_BIT]; // see R2
	assign mif.col_phase = col_ph;
	assign ram_addr = mif.ma;
	dmc_addr_mux u_mux (.m(mif.mux));
	assign ram_ras_n = (acc_st_r == dmc_pkg::DMC_IDLE);
	assign ram_cas_n = ~(col_ph && kind_r != dmc_pkg::DMC_K_REFR); // see R15
	assign ram_we_n = ~(col_ph && kind_r == dmc_pkg::DMC_K_CWR);
	assign ram_doe = ~ram_we_n;
	assign ram_dout = copy_data_r;

	// video side outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rgbi <= 4'h0;
			hblank <= 1'b0;
			underline <= 1'b0;
		end else begin
			rgbi <= (hsync_in || vsync_in || in_blank) ? 4'h0 : pix_rgbi; // see R11
			hblank <= in_blank; // see R12 // see R13
			underline <= disp_act && (scan_r == uline_r[dmc_pkg::ULINE_MSB:0]); // see R8
		end
	end

	a_col_16k : assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(col_ph && !charset_r[dmc_pkg::RAM_TYPE_BIT]) |-> ram_addr[0] == ram_addr[1])
		else $error("16k column lines 0 and 1 differ");
	a_col_64k : assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(col_ph && charset_r[dmc_pkg::RAM_TYPE_BIT]) |-> ram_addr == acc_addr_r[15:8])
		else $error("64k column address wrong");
	a_row_addr : assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(acc_st_r == dmc_pkg::DMC_ROW) |-> ram_addr == acc_addr_r[7:0])
		else $error("row address wrong");
	a_refresh_ras_only : assert property (@(posedge pclk) disable iff (!presetn) // see R15
		(acc_st_r != dmc_pkg::DMC_IDLE && kind_r == dmc_pkg::DMC_K_REFR) |-> ram_cas_n)
		else $error("refresh cycle strobed cas");
	a_sync_rgbi_low : assert property (@(posedge pclk) disable iff (!presetn) // see R11
		(hsync_in || vsync_in) |=> rgbi == 4'h0)
		else $error("colour driven during sync");
	a_copy_write_only : assert property (@(posedge pclk) disable iff (!presetn) // see R10
		!ram_we_n |-> (kind_r == dmc_pkg::DMC_K_CWR && copy_busy_r))
		else $error("ram write outside copy");

	c_refresh : cover property (@(posedge pclk) disable iff (!presetn)
		acc_st_r == dmc_pkg::DMC_ROW && kind_r == dmc_pkg::DMC_K_REFR);
	c_copy_write : cover property (@(posedge pclk) disable iff (!presetn) !ram_we_n);
	c_pattern : cover property (@(posedge pclk) disable iff (!presetn) pattern_valid);
endmodule // dmc_top
`default_nettype wire

//--- design/dmc_pkg.sv
// constants, register map and types of the display memory controller
// Functional notes
// R1 - sixteen-bit display addresses reach 64K bytes
// R2 - ram type bit selects address multiplexing
// R3 - 16Kx4 column uses a15,a13..a8,a8
// R4 - 64Kx1 row a7..a0, column a15..a8
// R5 - charset base gives top three address bits
// R6 - tall characters use only two base bits
// R7 - byte pointers fetched row-major from top
// R8 - underline on one selected scan line
// R9 - host sets up copy in fixed order
// R10 - copy reads source, writes destination, increments
// R11 - colour outputs low during sync
// R12 - blanking starts at blank begin count
// R13 - blanking ends after blank end count
// R14 - refresh count per line, every line
// R15 - refresh address increments, low byte row
// R16 - pattern address: base, pointer span, scan line
// R17 - refresh only in horizontal blanking
package dmc_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned PADDR_W = 8;
	// register byte addresses
	localparam logic [7:0] OFF_CHARSET = 8'h00;
	localparam logic [7:0] OFF_ULINE = 8'h04;
	localparam logic [7:0] OFF_SRC_HI = 8'h08;
	localparam logic [7:0] OFF_SRC_LO = 8'h0c;
	localparam logic [7:0] OFF_BLK_BEGIN = 8'h10;
	localparam logic [7:0] OFF_BLK_END = 8'h14;
	localparam logic [7:0] OFF_REFRESH = 8'h18;
	localparam logic [7:0] OFF_WCOUNT = 8'h1c;
	localparam logic [7:0] OFF_DST_HI = 8'h20;
	localparam logic [7:0] OFF_DST_LO = 8'h24;
	localparam logic [7:0] OFF_CTRL = 8'h28;
	localparam logic [7:0] OFF_STATUS = 8'h2c;
	localparam logic [7:0] OFF_LINE_TOT = 8'h30;
	localparam logic [7:0] OFF_DISP_HI = 8'h34;
	localparam logic [7:0] OFF_DISP_LO = 8'h38;
	// field positions
	localparam int unsigned RAM_TYPE_BIT = 4;
	localparam int unsigned CS_MSB = 7;
	localparam int unsigned CS_LSB = 5;
	localparam int unsigned COPY_MODE_BIT = 7;
	localparam int unsigned UPD_READY_BIT = 7;
	localparam int unsigned COPY_BUSY_BIT = 6;
	localparam int unsigned HEIGHT_MSB = 4;
	localparam int unsigned ULINE_MSB = 4;
	localparam int unsigned REFR_MSB = 3;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_LINE_TOT = 8'h63;
	localparam logic [7:0] RST_BLK_BEGIN = 8'h50;
	localparam logic [7:0] RST_BLK_END = 8'h5f;
	localparam logic [7:0] RST_REFRESH = 8'h05;
	localparam logic [4:0] RST_HEIGHT = 5'h07;
	// character layout
	localparam logic [4:0] SHORT_HEIGHT_MAX = 5'h0f;
	localparam int unsigned SPAN_SHIFT_SHORT = 4;
	localparam int unsigned SPAN_SHIFT_TALL = 5;
	// slot timing: two memory accesses of four cycles per character slot
	localparam logic [2:0] SLOT_LAST = 3'h7;
	localparam logic [2:0] SLOT_ACC0 = 3'h0;
	localparam logic [2:0] SLOT_ACC1 = 3'h4;
	localparam logic [31:0] APB_OK = 32'h0000_0000;

	typedef enum logic [1:0] {
		DMC_IDLE = 2'b00,
		DMC_ROW = 2'b01,
		DMC_COL = 2'b11,
		DMC_END = 2'b10
	} dmc_acc_t;

	typedef enum logic [2:0] {
		DMC_K_NONE = 3'h0,
		DMC_K_REFR = 3'h1,
		DMC_K_PTR = 3'h2,
		DMC_K_PAT = 3'h3,
		DMC_K_CRD = 3'h4,
		DMC_K_CWR = 3'h5
	} dmc_kind_t;
endpackage

//--- design/dmc_mux_if.sv
// address multiplexer link between access sequencer and row/column mux
`timescale 1ns/1ps
`default_nettype none
interface dmc_mux_if;
	logic [15:0] addr;
	logic        ram_type;
	logic        col_phase;
	logic [7:0]  ma;
	modport seq (output addr, output ram_type, output col_phase, input ma);
	modport mux (input addr, input ram_type, input col_phase, output ma);
endinterface // dmc_mux_if
`default_nettype wire

//--- design/dmc_addr_mux.sv
// dram row/column address multiplexer for both memory organisations
`timescale 1ns/1ps
`default_nettype none
module dmc_addr_mux (
	dmc_mux_if.mux m
);
	logic [7:0] col_addr;

	always_comb begin
		if (m.ram_type) begin
			col_addr = m.addr[15:8]; // see R4
		end else begin
			// 16Kx4 parts have one column line fewer, a8 appears twice
			col_addr = {m.addr[15], m.addr[13:8], m.addr[8]}; // see R3
		end
	end

	assign m.ma = m.col_phase ? col_addr : m.addr[7:0]; // see R2
endmodule // dmc_addr_mux
`default_nettype wire

//--- bench/dmc_dram_model.sv
// behavioural dedicated display dram answering the controller's ras/cas cycles
`timescale 1ns/1ps
`default_nettype none
module dmc_dram_model (
	input  wire logic       pclk,
	input  wire logic [7:0] ram_addr,
	input  wire logic       ram_ras_n,
	input  wire logic       ram_cas_n,
	input  wire logic       ram_we_n,
	input  wire logic [7:0] ram_dout,
	input  wire logic       ram_doe,
	output logic [7:0]      ram_din
);
	logic [7:0] mem [0:65535];
	logic [7:0] row_r;
	logic [7:0] last_r;
	logic       ras_q;
	logic       cas_q;
	initial begin
		row_r = 8'h00;
		last_r = 8'h00;
		ras_q = 1'b1;
		cas_q = 1'b1;
	end
	// row latched as ras falls, also the whole of a ras-only refresh
	always @(posedge pclk) begin
		ras_q <= ram_ras_n;
		cas_q <= ram_cas_n;
		if (ras_q && !ram_ras_n)
			row_r <= ram_addr;
		if (cas_q && !ram_cas_n && !ram_we_n && ram_doe)
			mem[{ram_addr, row_r}] <= ram_dout;
		if (!ram_cas_n && ram_we_n)
			last_r <= ram_din;
	end
	// released bus shows the inverse of the last value, never a held copy
	assign ram_din = (!ram_cas_n && ram_we_n) ? mem[{ram_addr, row_r}] : ~last_r;
endmodule // dmc_dram_model
`default_nettype wire

//--- bench/dmc_top_tb.sv
// self-checking bench for the display memory controller
`timescale 1ns/1ps
`default_nettype none
module dmc_top_tb;
	typedef struct {logic [7:0] a; logic [31:0] d;} dmc_row_t;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, hsync_in, vsync_in, vborder_in;
	logic [3:0]  pix_rgbi, rgbi;
	logic        hblank, underline, pattern_valid, ram_ras_n, ram_cas_n, ram_we_n, ram_doe;
	logic [7:0]  pattern_data, ram_addr, ram_dout, ram_din;
	int          n_mismatch, n_checks, i;
	dmc_row_t    rows [7];
	dmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hsync_in(hsync_in), .vsync_in(vsync_in), .vborder_in(vborder_in), .pix_rgbi(pix_rgbi),
		.rgbi(rgbi), .hblank(hblank), .underline(underline), .pattern_data(pattern_data),
		.pattern_valid(pattern_valid), .ram_addr(ram_addr), .ram_ras_n(ram_ras_n),
		.ram_cas_n(ram_cas_n), .ram_we_n(ram_we_n), .ram_dout(ram_dout), .ram_doe(ram_doe),
		.ram_din(ram_din));
	dmc_dram_model dram (.pclk(pclk), .ram_addr(ram_addr), .ram_ras_n(ram_ras_n),
		.ram_cas_n(ram_cas_n), .ram_we_n(ram_we_n), .ram_dout(ram_dout), .ram_doe(ram_doe),
		.ram_din(ram_din));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// request held until pready is sampled high; one idle edge follows
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200)
			n_mismatch++;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll(input int bitn, input logic val);
		int n;
		n = 0;
		rd = 32'h0000_0000;
		rd[bitn] = ~val;
		while (rd[bitn] !== val && n < 2000) begin
			apb(1'b0, dmc_pkg::OFF_STATUS, 32'h0000_0000);
			n++;
		end
		chk("status poll", {31'h0000_0000, val}, {31'h0000_0000, rd[bitn]});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge pclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		{presetn, psel, penable, pwrite, hsync_in, vsync_in, vborder_in} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pix_rgbi = 4'h0;
		rows = '{'{dmc_pkg::OFF_CHARSET, 32'h0000_00f0}, '{dmc_pkg::OFF_ULINE, 32'h0000_0013},
			'{dmc_pkg::OFF_SRC_HI, 32'h0000_0012}, '{dmc_pkg::OFF_SRC_LO, 32'h0000_0034},
			'{dmc_pkg::OFF_BLK_BEGIN, 32'h0000_0040}, '{dmc_pkg::OFF_BLK_END, 32'h0000_004f},
			'{dmc_pkg::OFF_REFRESH, 32'h0000_000a}};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[k]) begin
			apb(1'b1, rows[k].a, rows[k].d);
			apb(1'b0, rows[k].a, 32'h0000_0000);
			chk("register readback", rows[k].d, {24'h00_0000, rd[7:0]});
		end
		$display("test register table done");
		// second reset in mid-run must restore the documented defaults
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, dmc_pkg::OFF_BLK_BEGIN, 32'h0000_0000);
		chk("blank begin reset", {24'h00_0000, dmc_pkg::RST_BLK_BEGIN}, rd);
		apb(1'b0, dmc_pkg::OFF_BLK_END, 32'h0000_0000);
		chk("blank end reset", {24'h00_0000, dmc_pkg::RST_BLK_END}, rd);
		apb(1'b0, dmc_pkg::OFF_REFRESH, 32'h0000_0000);
		chk("refresh reset", {24'h00_0000, dmc_pkg::RST_REFRESH}, rd);
		$display("test reset values done");
		// 64Kx1 mode makes the model key equal the linear address
		apb(1'b1, dmc_pkg::OFF_CHARSET, 32'h0000_0010);
		for (i = 0; i < 4; i++)
			dram.mem[16'h1200 + i] = 8'h5a ^ i[7:0];
		apb(1'b1, dmc_pkg::OFF_DST_HI, 32'h0000_0034);
		apb(1'b1, dmc_pkg::OFF_DST_LO, 32'h0000_0000);
		poll(dmc_pkg::UPD_READY_BIT, 1'b1);
		apb(1'b1, dmc_pkg::OFF_CTRL, 32'h0000_0080);
		apb(1'b1, dmc_pkg::OFF_SRC_HI, 32'h0000_0012);
		apb(1'b1, dmc_pkg::OFF_SRC_LO, 32'h0000_0000);
		apb(1'b1, dmc_pkg::OFF_WCOUNT, 32'h0000_0004);
		poll(dmc_pkg::COPY_BUSY_BIT, 1'b0);
		for (i = 0; i < 5; i++)
			chk("copied byte", {24'h00_0000, (i < 4) ? 8'h5a ^ i[7:0] : 8'hxx}, {24'h00_0000, dram.mem[16'h3400 + i]});
		$display("test block copy done");
		pix_rgbi <= 4'hf;
		hsync_in <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("rgbi in hsync", 32'h0000_0000, {28'h000_0000, rgbi});
		hsync_in <= 1'b0;
		vsync_in <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("rgbi in vsync", 32'h0000_0000, {28'h000_0000, rgbi});
		vsync_in <= 1'b0;
		$display("test sync blanking done");
		finish_test;
	end
endmodule // dmc_top_tb
`default_nettype wire
